// ===== rph_pkg.sv
// Constants, types and shared functions of the radio packet handler
// ==========================================================
package rph_pkg;
  localparam logic [7:0]  RPH_PRE_BYTE = 8'hAA;
  localparam logic [7:0]  RPH_BC_LO    = 8'h00;
  localparam logic [7:0]  RPH_BC_HI    = 8'hFF;
  localparam logic [1:0]  RPH_LEN_FIX  = 2'h0;
  localparam logic [1:0]  RPH_LEN_VAR  = 2'h1;
  localparam logic [1:0]  RPH_LEN_INF  = 2'h2;
  localparam logic [1:0]  RPH_ADR_OFF  = 2'h0;
  localparam logic [1:0]  RPH_ADR_BC0  = 2'h2;
  localparam logic [1:0]  RPH_ADR_BC2  = 2'h3;
  localparam logic [2:0]  RPH_SYNC32_A = 3'h3;
  localparam logic [2:0]  RPH_SYNC32_B = 3'h7;
  localparam logic [15:0] RPH_CRC_POLY = 16'h8005;
  localparam logic [15:0] RPH_CRC_INIT = 16'hFFFF;
  localparam logic [8:0]  RPH_PN9_INIT = 9'h1FF;
  localparam int          RPH_DEPTH    = 16;
  localparam int          RPH_RX_ROOM  = 3;

  typedef struct packed {
    logic [7:0] sync_word_high;
    logic [7:0] sync_word_low;
    logic [7:0] packet_length_limit;
    logic [1:0] length_mode;
    logic [1:0] address_check_mode;
    logic [7:0] node_address;
    logic [2:0] sync_mode;
    logic [7:0] preamble_count;
    logic       crc_enable;
    logic       whitening_enable;
    logic       bad_crc_flush;
    logic       status_append_enable;
  } rph_cfg_type;

  typedef struct packed {
    logic [7:0] rssi;
    logic [6:0] link_quality;
  } rph_meta_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_PRE = 3'h1, TX_SYNC = 3'h2, TX_DATA = 3'h3,
    TX_CRC  = 3'h4, TX_END = 3'h5, TX_STARVED = 3'h6
  } rph_tx_state_type;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h0, RX_LEN = 3'h1, RX_MARK = 3'h2, RX_ADDR = 3'h3,
    RX_DATA = 3'h4, RX_CRC = 3'h5, RX_STAT = 3'h6
  } rph_rx_state_type;

  function automatic logic [15:0] rph_crc(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ RPH_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [8:0] rph_pn9(input logic [8:0] p);
    logic [8:0] r;
    r = p;
    for (int i = 0; i < 8; i++) begin
      r = {r[0] ^ r[5], r[8:1]};
    end
    return r;
  endfunction

  function automatic logic rph_end(input logic [1:0] m, input logic [7:0] c, input logic [7:0] lim,
                                   input logic [7:0] len);
    return (m == RPH_LEN_FIX && c == lim) || (m == RPH_LEN_VAR && c == len);
  endfunction

  function automatic logic rph_sync32(input logic [2:0] m);
    return m == RPH_SYNC32_A || m == RPH_SYNC32_B;
  endfunction
endpackage

// ===== rph_packet_handler.sv
// Packet handler: byte FIFO and the TX framer / RX filter top
`timescale 1ns/1ps

// ==========================================================
// Byte FIFO with flush and packet rewind
module rph_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  input  wire logic             flush,
  input  wire logic             mark,
  input  wire logic             rewind,
  output logic      [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
    logic [AW:0]                 mk;
    logic [AW:0]                 lvl;
    logic                        rdy;
    logic                        vld;
  } rph_fifo_state_type;
  rph_fifo_state_type s_q, s_d;
  logic [AW:0]        gone;

  always_comb begin
    s_d = s_q;
    gone = '0;
    if (in_valid && s_q.rdy) begin
      s_d.mem[s_q.wp[AW-1:0]] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (out_ready && s_q.vld) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (mark) begin
      s_d.mk = s_q.wp;
    end
    // Bytes already read past the mark stay delivered; wp drops back to rp, or to the mark if rp has not reached it, so only unread packet bytes go
    if (rewind) begin
      gone = s_d.rp - s_q.mk;
      s_d.wp = (gone <= s_q.wp - s_q.mk) ? s_d.rp : s_q.mk;
    end
    if (flush) begin
      s_d.rp = s_d.wp;
      s_d.mk = s_d.wp;
    end
    s_d.lvl = s_d.wp - s_d.rp;
    s_d.rdy = s_d.lvl != (AW+1)'(DEPTH);
    s_d.vld = s_d.lvl != '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{mem: '0, wp: '0, rp: '0, mk: '0, lvl: '0, rdy: 1'b1, vld: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = s_q.rdy;
  assign out_valid = s_q.vld;
  assign out_data  = s_q.mem[s_q.rp[AW-1:0]];
  assign level     = s_q.lvl;
endmodule

// ==========================================================
// Packet handler top
module rph_packet_handler
  import rph_pkg::*;
#(
  parameter int DEPTH = RPH_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire rph_cfg_type  cfg,
  input  wire logic         tx_enable,
  input  wire logic         tx_fifo_flush_strobe,
  input  wire logic         host_tx_valid,
  input  wire logic [7:0]   host_tx_data,
  output logic              host_tx_ready,
  output logic              mod_valid,
  output logic      [7:0]   mod_data,
  input  wire logic         mod_ready,
  output logic              tx_starved_state,
  output logic              tx_done,
  input  wire logic         rx_enable,
  input  wire logic         demod_sync,
  input  wire logic         demod_valid,
  input  wire logic [7:0]   demod_data,
  output logic              demod_ready,
  input  wire rph_meta_type rx_meta,
  output logic              host_rx_valid,
  output logic      [7:0]   host_rx_data,
  input  wire logic         host_rx_ready,
  output logic              rx_done,
  output logic              rx_crc_ok,
  output logic              rx_discard
);
  localparam int LW = $clog2(DEPTH) + 1;
  typedef struct packed {
    rph_tx_state_type tst;
    logic [7:0]       tcnt;
    logic [7:0]       pcnt;
    logic [7:0]       tlen;
    logic [1:0]       tidx;
    logic             tfirst;
    logic [15:0]      tcrc;
    logic [8:0]       tpn;
    logic             mv;
    logic [7:0]       md;
    logic             starved;
    logic             tdone;
    rph_rx_state_type rst;
    logic [7:0]       rcnt;
    logic [7:0]       rlen;
    logic [1:0]       ridx;
    logic [15:0]      rcrc;
    logic [8:0]       rpn;
    logic             rok;
    logic             rrdy;
    logic             rdone;
    logic             rcok;
    logic             rdisc;
  } rph_state_type;

  rph_state_type s_q, s_d;
  logic [1:0]    rs_q;
  logic          rst_n;
  logic          tf_vld, tf_pop, take, is_len, acc, adr_ok, rf_wv, rf_rdy;
  logic          rf_mark, rf_rew, rf_flush;
  logic [7:0]    tf_data, tb, db, rf_wd;
  logic [15:0]   rcrc_n;
  logic [LW-1:0] rf_lvl;

  // ==========================================================
  // Reset release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  rph_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
    .clk(ref_clk), .rst_n(rst_n), .in_valid(host_tx_valid), .in_data(host_tx_data),
    .in_ready(host_tx_ready), .out_valid(tf_vld), .out_data(tf_data), .out_ready(tf_pop),
    .flush(tx_fifo_flush_strobe), .mark(1'b0), .rewind(1'b0), .level()
  );

  rph_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxf (
    .clk(ref_clk), .rst_n(rst_n), .in_valid(rf_wv), .in_data(rf_wd), .in_ready(rf_rdy),
    .out_valid(host_rx_valid), .out_data(host_rx_data), .out_ready(host_rx_ready),
    .flush(rf_flush), .mark(rf_mark), .rewind(rf_rew), .level(rf_lvl)
  );

  // ==========================================================
  // Transmit framer
  always_comb begin
    s_d = s_q;
    s_d.tdone = 1'b0;
    tf_pop = 1'b0;
    is_len = 1'b0;
    tb = 8'h00;
    take = !s_q.mv || mod_ready;
    if (take) begin
      s_d.mv = 1'b0;
    end
    unique case (s_q.tst)
      TX_IDLE: if (tx_enable) begin
        s_d.tst = TX_PRE;
        s_d.pcnt = 8'h00;
      end
      TX_PRE: if (take) begin
        s_d.mv = 1'b1;
        s_d.md = RPH_PRE_BYTE;
        s_d.pcnt = (s_q.pcnt == 8'hFF) ? s_q.pcnt : s_q.pcnt + 8'h01;
        if (s_d.pcnt >= cfg.preamble_count && tf_vld) begin
          s_d.tst = TX_SYNC;
          s_d.tidx = 2'h0;
        end
      end
      TX_SYNC: if (take) begin
        s_d.mv = 1'b1;
        s_d.md = s_q.tidx[0] ? cfg.sync_word_low : cfg.sync_word_high;
        s_d.tidx = s_q.tidx + 2'h1;
        if (s_q.tidx == (rph_sync32(cfg.sync_mode) ? 2'h3 : 2'h1)) begin
          s_d.tst = TX_DATA;
          s_d.tcrc = RPH_CRC_INIT;
          s_d.tpn = RPH_PN9_INIT;
          s_d.tfirst = 1'b1;
          s_d.tcnt = 8'h00;
        end
      end
      TX_DATA: if (take) begin
        if (!tf_vld) begin
          s_d.tst = TX_STARVED;
          s_d.starved = 1'b1;
        end else begin
          tf_pop = 1'b1;
          is_len = s_q.tfirst && cfg.length_mode == RPH_LEN_VAR;
          s_d.tfirst = 1'b0;
          s_d.tcrc = rph_crc(s_q.tcrc, tf_data);
          s_d.md = cfg.whitening_enable ? tf_data ^ s_q.tpn[7:0] : tf_data;
          s_d.tpn = rph_pn9(s_q.tpn);
          s_d.mv = 1'b1;
          if (is_len) begin
            s_d.tlen = tf_data;
          end else begin
            s_d.tcnt = s_q.tcnt + 8'h01;
          end
          if (!is_len && rph_end(cfg.length_mode, s_d.tcnt, cfg.packet_length_limit, s_q.tlen)) begin
            s_d.tst = cfg.crc_enable ? TX_CRC : TX_END;
            s_d.tidx = 2'h0;
            s_d.tdone = !cfg.crc_enable;
          end
        end
      end
      TX_CRC: if (take) begin
        tb = s_q.tidx[0] ? s_q.tcrc[7:0] : s_q.tcrc[15:8];
        s_d.mv = 1'b1;
        s_d.md = cfg.whitening_enable ? tb ^ s_q.tpn[7:0] : tb;
        s_d.tpn = rph_pn9(s_q.tpn);
        s_d.tidx = 2'h1;
        if (s_q.tidx[0]) begin
          s_d.tst = TX_END;
          s_d.tdone = 1'b1;
        end
      end
      TX_END: if (!tx_enable) begin
        s_d.tst = TX_IDLE;
      end
      TX_STARVED: if (tx_fifo_flush_strobe) begin
        s_d.tst = TX_IDLE;
        s_d.starved = 1'b0;
      end
      default: s_d.tst = TX_IDLE;
    endcase
    if (!tx_enable && s_q.tst != TX_STARVED && s_q.tst != TX_END) begin
      s_d.tst = TX_IDLE;
    end

    // ==========================================================
    // Receive filter
    s_d.rdone = 1'b0;
    s_d.rdisc = 1'b0;
    acc = demod_valid && s_q.rrdy;
    db = cfg.whitening_enable ? demod_data ^ s_q.rpn[7:0] : demod_data;
    rcrc_n = rph_crc(s_q.rcrc, db);
    rf_wv = 1'b0;
    rf_wd = db;
    rf_mark = 1'b0;
    rf_rew = 1'b0;
    rf_flush = 1'b0;
    adr_ok = db == cfg.node_address
      || (cfg.address_check_mode >= RPH_ADR_BC0 && db == RPH_BC_LO)
      || (cfg.address_check_mode == RPH_ADR_BC2 && db == RPH_BC_HI);
    if (acc) begin
      s_d.rpn = rph_pn9(s_q.rpn);
    end
    unique case (s_q.rst)
      RX_HUNT: if (demod_sync && rx_enable) begin
        rf_mark = 1'b1;
        s_d.rpn = RPH_PN9_INIT;
        s_d.rcrc = RPH_CRC_INIT;
        s_d.rcnt = 8'h00;
        s_d.rok = 1'b1;
        s_d.ridx = 2'h0;
        if (cfg.length_mode == RPH_LEN_VAR) begin
          s_d.rst = RX_LEN;
        end else if (cfg.address_check_mode == RPH_ADR_OFF) begin
          s_d.rst = RX_DATA;
        end else begin
          s_d.rst = (cfg.length_mode == RPH_LEN_INF) ? RX_MARK : RX_ADDR;
        end
      end
      RX_LEN: if (acc) begin
        if (db == 8'h00 || db > cfg.packet_length_limit) begin
          rf_rew = 1'b1;
          s_d.rdisc = 1'b1;
          s_d.rst = RX_HUNT;
        end else begin
          rf_wv = 1'b1;
          s_d.rlen = db;
          s_d.rcrc = rcrc_n;
          s_d.rst = (cfg.address_check_mode != RPH_ADR_OFF) ? RX_ADDR : RX_DATA;
        end
      end
      RX_MARK: if (rf_rdy) begin
        rf_wv = 1'b1;
        rf_wd = RPH_BC_HI;
        s_d.rst = RX_ADDR;
      end
      RX_ADDR, RX_DATA: if (acc) begin
        if (s_q.rst == RX_ADDR && !adr_ok) begin
          rf_rew = 1'b1;
          s_d.rdisc = 1'b1;
          s_d.rst = RX_HUNT;
        end else begin
          rf_wv = 1'b1;
          s_d.rcrc = rcrc_n;
          s_d.rcnt = s_q.rcnt + 8'h01;
          s_d.rst = RX_DATA;
          if (rph_end(cfg.length_mode, s_d.rcnt, cfg.packet_length_limit, s_q.rlen)) begin
            s_d.ridx = 2'h0;
            if (cfg.crc_enable) begin
              s_d.rst = RX_CRC;
            end else if (cfg.status_append_enable) begin
              s_d.rst = RX_STAT;
            end else begin
              s_d.rst = RX_HUNT;
              s_d.rdone = 1'b1;
              s_d.rcok = 1'b1;
            end
          end
        end
      end
      RX_CRC: if (acc) begin
        s_d.rcrc = rcrc_n;
        s_d.ridx = 2'h1;
        if (s_q.ridx[0]) begin
          s_d.rok = rcrc_n == 16'h0000;
          s_d.ridx = 2'h0;
          if (!s_d.rok && cfg.bad_crc_flush) begin
            rf_flush = 1'b1;
            s_d.rst = RX_HUNT;
            s_d.rdone = 1'b1;
            s_d.rcok = 1'b0;
          end else if (cfg.status_append_enable) begin
            s_d.rst = RX_STAT;
          end else begin
            s_d.rst = RX_HUNT;
            s_d.rdone = 1'b1;
            s_d.rcok = s_d.rok;
          end
        end
      end
      RX_STAT: if (rf_rdy) begin
        rf_wv = 1'b1;
        rf_wd = s_q.ridx[0] ? {s_q.rok, rx_meta.link_quality} : rx_meta.rssi;
        s_d.ridx = 2'h1;
        if (s_q.ridx[0]) begin
          s_d.rst = RX_HUNT;
          s_d.rdone = 1'b1;
          s_d.rcok = s_q.rok;
        end
      end
      default: s_d.rst = RX_HUNT;
    endcase
    if (!rx_enable && s_q.rst != RX_HUNT) begin
      s_d.rst = RX_HUNT;
    end
    s_d.rrdy = (s_d.rst == RX_LEN || s_d.rst == RX_ADDR || s_d.rst == RX_DATA || s_d.rst == RX_CRC)
      && rf_lvl <= LW'(DEPTH - RPH_RX_ROOM);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mod_valid        = s_q.mv;
  assign mod_data         = s_q.md;
  assign tx_starved_state = s_q.starved;
  assign tx_done          = s_q.tdone;
  assign demod_ready      = s_q.rrdy;
  assign rx_done          = s_q.rdone;
  assign rx_crc_ok        = s_q.rcok;
  assign rx_discard       = s_q.rdisc;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_mark;
    s_q.rst == RX_MARK && rf_rdy && rx_enable;
  endsequence
  sequence seq_after_mark;
    rf_wd == RPH_BC_HI ##1 s_q.rst == RX_ADDR;
  endsequence

  a_pre_pattern: assert property ((s_q.tst == TX_PRE && take && tx_enable) |=>
    (mod_valid && mod_data == RPH_PRE_BYTE)) else $error("preamble byte wrong");
  a_pre_hold: assert property ((s_q.tst == TX_PRE && !tf_vld && tx_enable) |=>
    s_q.tst == TX_PRE) else $error("left preamble without data");
  a_sync_len: assert property ((s_q.tst == TX_SYNC && take && s_q.tidx == 2'h1 && tx_enable) |=>
    ((s_q.tst == TX_SYNC) == rph_sync32($past(cfg.sync_mode)))) else $error("sync length wrong");
  a_starve_hold: assert property ((s_q.tst == TX_STARVED && !tx_fifo_flush_strobe) |=>
    (s_q.tst == TX_STARVED && tx_starved_state)) else $error("left starved state");
  a_len_reject: assert property ((s_q.rst == RX_LEN && acc && db > cfg.packet_length_limit) |=>
    (rx_discard && s_q.rst == RX_HUNT)) else $error("oversized packet kept");
  a_addr_reject: assert property ((s_q.rst == RX_ADDR && acc && !adr_ok) |->
    (rf_rew && !rf_wv) ##1 rx_discard) else $error("address miss kept");
  a_mark_first: assert property (seq_mark |-> seq_after_mark)
    else $error("marker byte missing");
  a_crc_flush: assert property (rf_flush |=> (!host_rx_valid && rx_done && !rx_crc_ok))
    else $error("bad packet not flushed");
  a_status_crc: assert property ((s_q.rst == RX_STAT && s_q.ridx[0] && rf_rdy && rx_enable) |->
    (rf_wv && rf_wd[7] == s_q.rok) ##1 (rx_done && rx_crc_ok == $past(s_q.rok))) else $error("status byte wrong");
endmodule

// ===== rph_host_model.sv
// Host model: fills the TX FIFO and drains the RX FIFO
`timescale 1ns/1ps
// ==========================================================
// Host side of both FIFOs
module rph_host_model (
  input  wire logic       ref_clk,
  output logic            host_tx_valid,
  output logic [7:0]      host_tx_data,
  input  wire logic       host_tx_ready,
  input  wire logic       host_rx_valid,
  input  wire logic [7:0] host_rx_data,
  output logic            host_rx_ready
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic       stall = 1'b0;
  initial begin
    host_tx_valid = 1'b0;
    host_tx_data  = 8'h00;
  end
  assign host_rx_ready = !stall;
  always @(posedge ref_clk) begin
    if (host_tx_valid && host_tx_ready) begin
      void'(tx_q.pop_front());
    end
    if (host_rx_valid && host_rx_ready) begin
      rx_q.push_back(host_rx_data);
    end
    #1;
    host_tx_valid = tx_q.size() > 0;
    host_tx_data  = host_tx_valid ? tx_q[0] : ~host_tx_data;
  end
endmodule

// ===== radio_packet_handler_tb_top.sv
// Testbench top of the radio packet handler
`timescale 1ns/1ps
module radio_packet_handler_tb_top;
  import rph_pkg::*;
  // ==========================================================
  // Signals, design and host model
  logic         ref_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         slow = 1'b0;
  logic         mod_ready = 1'b1;
  rph_cfg_type  cfg;
  rph_cfg_type  base;
  rph_meta_type rx_meta;
  logic         tx_enable, tx_fifo_flush_strobe, mod_valid, tx_starved_state, tx_done;
  logic         host_tx_valid, host_tx_ready, rx_enable, demod_sync, demod_valid, demod_ready;
  logic         host_rx_valid, host_rx_ready, rx_done, rx_crc_ok, rx_discard;
  logic [7:0]   mod_data, host_tx_data, demod_data, host_rx_data;
  logic [7:0]   mq[$];
  logic [7:0]   e[$];
  int           error_cnt = 0;
  int           checked = 0;
  int           n_done = 0;
  int           n_rxd = 0;
  int           n_disc = 0;
  int           npre;

  always #5 ref_clk = ~ref_clk;

  rph_packet_handler dut (.ref_clk, .nrst, .cfg, .tx_enable, .tx_fifo_flush_strobe, .host_tx_valid,
    .host_tx_data, .host_tx_ready, .mod_valid, .mod_data, .mod_ready, .tx_starved_state, .tx_done,
    .rx_enable, .demod_sync, .demod_valid, .demod_data, .demod_ready, .rx_meta, .host_rx_valid,
    .host_rx_data, .host_rx_ready, .rx_done, .rx_crc_ok, .rx_discard);

  rph_host_model host (.ref_clk, .host_tx_valid, .host_tx_data, .host_tx_ready, .host_rx_valid,
    .host_rx_data, .host_rx_ready);

  always @(posedge ref_clk) begin
    if (mod_valid && mod_ready) begin
      mq.push_back(mod_data);
    end
    n_done += int'(tx_done);
    n_rxd  += int'(rx_done);
    n_disc += int'(rx_discard);
    #1;
    mod_ready <= slow ? ~mod_ready : 1'b1;
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
    return c;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic ck8(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic ck1(input string n, input logic x, input logic g);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", n, x, g);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tx_run();
    int k = 0;
    mq = {};
    n_done = 0;
    npre = 0;
    tx_enable = 1'b1;
    while (n_done == 0 && k < 600) begin
      cyc(1);
      k++;
    end
    cyc(3);
    tx_enable = 1'b0;
    cyc(3);
    ck8("tx_done", 8'h01, 8'(n_done));
    while (mq.size() > 0 && mq[0] === 8'hAA) begin
      void'(mq.pop_front());
      npre++;
    end
    ck8("tx_len", 8'(e.size()), 8'(mq.size()));
    foreach (e[i]) ck8("tx_byte", e[i], mq[i]);
  endtask

  task automatic rx_pkt(input logic [7:0] d[$], input logic bad);
    logic [15:0] c = 16'hFFFF;
    int k;
    foreach (d[i]) c = crc16(c, d[i]);
    d.push_back(c[15:8] ^ {7'h00, bad});
    d.push_back(c[7:0]);
    n_rxd = 0;
    n_disc = 0;
    host.stall = 1'b1;
    demod_sync = 1'b1;
    cyc(1);
    demod_sync = 1'b0;
    foreach (d[i]) begin
      if (n_disc != 0) break;
      demod_valid = 1'b1;
      demod_data = d[i];
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (!demod_ready && k < 50);
      #1;
    end
    demod_valid = 1'b0;
    demod_data = ~demod_data;
    k = 0;
    while (n_rxd == 0 && n_disc == 0 && k < 60) begin
      cyc(1);
      k++;
    end
    cyc(4);
    host.stall = 1'b0;
    cyc(8);
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_fix();
    logic [2:0]  sm[3] = '{3'h2, 3'h3, 3'h7};
    logic [7:0]  d[3] = '{8'h11, 8'h22, 8'h33};
    logic [15:0] c;
    cfg.crc_enable = 1'b1;
    slow = 1'b1;
    foreach (sm[j]) begin
      cfg.sync_mode = sm[j];
      c = 16'hFFFF;
      e = {8'h3C, 8'hD2};
      if (j > 0) e = {8'h3C, 8'hD2, 8'h3C, 8'hD2};
      foreach (d[i]) begin
        c = crc16(c, d[i]);
        e.push_back(d[i]);
      end
      e.push_back(c[15:8]);
      e.push_back(c[7:0]);
      host.tx_q = {8'h11, 8'h22, 8'h33};
      cyc(6);
      tx_run();
      ck8("pre_cnt", 8'h02, 8'(npre));
    end
    slow = 1'b0;
  endtask

  task automatic s_white();
    logic [8:0] p = 9'h1FF;
    logic [7:0] d[3] = '{8'h02, 8'h5A, 8'hA5};
    cfg = base;
    cfg.length_mode = RPH_LEN_VAR;
    cfg.whitening_enable = 1'b1;
    cfg.preamble_count = 8'h01;
    cfg.packet_length_limit = 8'h10;
    e = {8'h3C, 8'hD2};
    foreach (d[i]) begin
      e.push_back(d[i] ^ p[7:0]);
      repeat (8) p = {p[0] ^ p[5], p[8:1]};
    end
    fork
      tx_run();
      begin
        cyc(30);
        host.tx_q = {8'h02, 8'h5A, 8'hA5};
      end
    join
    ck1("pre_extra", 1'b1, npre > 2);
  endtask

  task automatic s_starve();
    int sz;
    cfg = base;
    cfg.packet_length_limit = 8'h04;
    host.tx_q = {8'h01, 8'h02};
    tx_enable = 1'b1;
    cyc(60);
    ck1("starved", 1'b1, tx_starved_state);
    sz = mq.size();
    host.tx_q = {8'h03};
    cyc(20);
    ck1("still_starved", 1'b1, tx_starved_state);
    ck8("no_restart", 8'(sz), 8'(mq.size()));
    tx_fifo_flush_strobe = 1'b1;
    cyc(1);
    tx_fifo_flush_strobe = 1'b0;
    cyc(2);
    ck1("flushed", 1'b0, tx_starved_state);
    tx_enable = 1'b0;
    cyc(4);
  endtask

  task automatic s_addr();
    logic [1:0] am[5] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h3};
    logic [7:0] ad[5] = '{8'h42, 8'h00, 8'hFF, 8'h00, 8'hFF};
    logic       ok[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    cfg = base;
    cfg.length_mode = RPH_LEN_VAR;
    cfg.crc_enable = 1'b1;
    cfg.status_append_enable = 1'b1;
    cfg.packet_length_limit = 8'h02;
    foreach (am[j]) begin
      cfg.address_check_mode = am[j];
      host.rx_q = {};
      rx_pkt({8'h02, ad[j], 8'h5E}, 1'b0);
      ck1("addr_drop", !ok[j], n_disc != 0);
      ck8("rx_count", ok[j] ? 8'h05 : 8'h00, 8'(host.rx_q.size()));
    end
    e = {8'h02, 8'hFF, 8'h5E, 8'h9C, 8'hB5};
    foreach (e[i]) ck8("rx_byte", e[i], host.rx_q[i]);
    cfg.packet_length_limit = 8'h01;
    host.rx_q = {};
    rx_pkt({8'h02, 8'hFF, 8'h5E}, 1'b0);
    ck1("len_drop", 1'b1, n_disc != 0);
    ck8("rx_count", 8'h00, 8'(host.rx_q.size()));
  endtask

  task automatic s_flush();
    logic bad[2] = '{1'b1, 1'b0};
    cfg.bad_crc_flush = 1'b1;
    cfg.status_append_enable = 1'b0;
    cfg.packet_length_limit = 8'h04;
    foreach (bad[j]) begin
      host.rx_q = {};
      host.stall = 1'b1;
      rx_pkt({8'h03, 8'h42, 8'h01, 8'h02}, bad[j]);
      ck1("crc_ok", !bad[j], rx_crc_ok);
      host.stall = 1'b0;
      cyc(10);
      ck8("rx_count", bad[j] ? 8'h00 : 8'h04, 8'(host.rx_q.size()));
    end
  endtask

  task automatic s_long();
    cfg = base;
    cfg.length_mode = RPH_LEN_INF;
    cfg.packet_length_limit = 8'h03;
    e = {8'h3C, 8'hD2};
    host.tx_q = {};
    for (int i = 0; i < 259; i++) begin
      e.push_back(8'(i + 1));
      host.tx_q.push_back(8'(i + 1));
    end
    cyc(20);
    mq = {};
    fork
      tx_run();
      begin
        while (mq.size() <= 30) cyc(1);
        cfg.length_mode = RPH_LEN_FIX;
      end
    join
  endtask

  task automatic s_inf();
    cfg = base;
    cfg.length_mode = RPH_LEN_INF;
    cfg.address_check_mode = 2'h1;
    host.rx_q = {};
    rx_pkt({8'h42, 8'h11}, 1'b0);
    ck8("rx_count", 8'h05, 8'(host.rx_q.size()));
    ck1("inf_no_end", 1'b0, n_rxd != 0);
    ck8("inf_marker", 8'hFF, host.rx_q[0]);
    ck8("inf_addr", 8'h42, host.rx_q[1]);
    ck8("inf_data", 8'h11, host.rx_q[2]);
    rx_enable = 1'b0;
    cyc(2);
    rx_enable = 1'b1;
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    tx_enable = 1'b0;
    tx_fifo_flush_strobe = 1'b0;
    rx_enable = 1'b1;
    demod_sync = 1'b0;
    demod_valid = 1'b0;
    demod_data = 8'h00;
    rx_meta = '{8'h9C, 7'h35};
    base = '{8'h3C, 8'hD2, 8'h03, 2'h0, 2'h0, 8'h42, 3'h2, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0};
    cfg = base;
    cyc(5);
    nrst = 1'b1;
    cyc(3);
    s_fix();
    s_white();
    s_starve();
    s_long();
    s_addr();
    s_flush();
    s_inf();
    close_out();
  end

  initial begin
    #100us;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    close_out();
  end
endmodule
